// ### verilog/adc_mix_defs.vh
// constants for the adc input-mix control register bank
// assumes inclusion by bare name from the design files
`ifndef ADC_MIX_DEFS_VH
`define ADC_MIX_DEFS_VH
`define MIX_OFS_RIGHT 8'h12
`define MIX_OFS_LEFT 8'h13
`define MIX_RST_RIGHT 8'hFF
`define MIX_RST_LEFT 8'h78
`define LVL_OFF 4'hF
`define LVL_MAX 4'h8
`define F_DIFF 7
`define F_LVL_HI 6
`define F_LVL_LO 3
`define F_PWR 2
`define SS_EVERY 2'h0
`define SS_EVERY2 2'h1
`define GAIN_W 7
`define GAIN_RST 7'h00
`define GAIN_STEP_CDB 10'h032
`define LVL_STEP_CDB 7'h0F
`endif

// ### verilog/gain_stepper.v
// soft-stepping of the adc gain-stage gain toward a target code
// assumes fs_tick is a one-cycle pulse on core_clk once per sample period
`timescale 1ns/1ns
`include "adc_mix_defs.vh"
module gain_stepper #(
	parameter W = 7
) (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// control
	input wire fs_tick,
	input wire [1:0] step_rate,
	input wire [W-1:0] gain_target,
	// result
	output reg [W-1:0] gain_q
);
	reg half_q;
	reg go;

	// pick stepping moments from the rate code
	always @* begin
		case (step_rate)
			`SS_EVERY: go = fs_tick;
			`SS_EVERY2: go = fs_tick & half_q;
			default: go = 1'b1; // disabled: jump at once
		endcase
	end

	// one 0.5 dB code per interval toward target
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gain_q <= `GAIN_RST;
			half_q <= 1'b0;
		end else begin
			if (fs_tick)
				half_q <= ~half_q;
			if (step_rate[1])
				gain_q <= gain_target;
			else if (go && gain_q < gain_target)
				gain_q <= gain_q + {{(W-1){1'b0}}, 1'b1};
			else if (go && gain_q > gain_target)
				gain_q <= gain_q - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // gain_stepper

// ### verilog/adc_input_mix_control_regs.v
// two input-mix control registers of the record path and their decoded controls
// assumes a serial-bus front end on core_clk delivers decoded byte writes and reads
`timescale 1ns/1ns
`include "adc_mix_defs.vh"

// register map, both bytes read and write
//   right mix byte: [7:4] third mic left level, [3:0] third mic right level
//   left mix byte: [7] line mode, [6:3] line level, [2] adc power, [1:0] step rate
// reset: right byte all ones, so both third mic inputs start unconnected;
// left byte has only the line level at ones, the adc starts powered down
// level codes 0 to 8 give 0 to -12 dB in 1.5 dB steps; 15 disconnects
// codes 9 to 14 are the host's to avoid; they are stored as written
// and decode like code 8, the deepest step, yet still count as connected
// step rate 0 steps once per sample, 1 once per two samples, 2 and 3 jump
//
// timing at the ports
//   a write taken at edge n lands in its byte at n
//   decoded controls follow one edge later
//   a read taken at edge n shows data and hit just after n
//   a write and a read in one cycle return the old byte
// the extra decode stage keeps every output on a flip-flop, paid for
// with one more cycle of latency on the analogue controls
module adc_input_mix_control_regs #(
	parameter GW = `GAIN_W
) (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// register access from the serial control front end
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_hit,
	// sample-period tick and gain-stage target
	input wire fs_tick,
	input wire [GW-1:0] left_gain_target,
	// decoded analogue controls
	output reg third_mic_left_conn,
	output reg [6:0] third_mic_left_atten_cdb,
	output reg third_mic_right_conn,
	output reg [6:0] third_mic_right_atten_cdb,
	output reg first_line_left_diff,
	output reg first_line_left_conn,
	output reg [6:0] first_line_left_atten_cdb,
	output reg left_adc_power,
	output reg [GW-1:0] left_gain_applied,
	output reg [9:0] left_gain_cdb
);
	// stored register bytes
	reg [7:0] right_mix_q;
	reg [7:0] left_mix_q;
	// stepped gain code from the stepper
	wire [GW-1:0] gain_now;
	// decoded access qualifiers
	wire wr_right;
	wire wr_left;
	wire rd_mapped;

	// attenuation in 0.1 dB units; reserved codes clamp to the deepest step
	function [6:0] atten_cdb;
		input [3:0] code;
		reg [3:0] c;
		begin
			c = (code > `LVL_MAX) ? `LVL_MAX : code;
			atten_cdb = c * `LVL_STEP_CDB;
		end
	endfunction

	// connection follows the level code alone, no separate switch
	function connected;
		input [3:0] code;
		begin
			connected = (code != `LVL_OFF);
		end
	endfunction

	// address of the right mix byte
	function is_right;
		input [7:0] addr;
		begin
			is_right = (addr == `MIX_OFS_RIGHT);
		end
	endfunction

	// address of the left mix byte
	function is_left;
		input [7:0] addr;
		begin
			is_left = (addr == `MIX_OFS_LEFT);
		end
	endfunction

	// write and read qualifiers; writes to other addresses are ignored, reads of them give zero data and no hit
	assign wr_right = reg_wr & is_right(reg_addr);
	assign wr_left = reg_wr & is_left(reg_addr);
	assign rd_mapped = is_right(reg_addr) | is_left(reg_addr);

	// register writes, taken on the edge that sees the strobe
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			right_mix_q <= `MIX_RST_RIGHT;
			left_mix_q <= `MIX_RST_LEFT;
		end else begin
			if (wr_right)
				right_mix_q <= reg_wdata;
			if (wr_left)
				left_mix_q <= reg_wdata;
		end
	end

	// soft-stepped gain stage, rate from the low two bits
	// the once-per-two phase runs freely from reset, not from the write
	gain_stepper #(
		.W(GW)
	) u_step (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.fs_tick(fs_tick),
		.step_rate(left_mix_q[1:0]),
		.gain_target(left_gain_target),
		.gain_q(gain_now)
	);

	// read port: data held until the next read, hit for one cycle
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else begin
			reg_hit <= reg_rd & rd_mapped;
			if (reg_rd) begin
				if (is_right(reg_addr))
					reg_rdata <= right_mix_q;
				else if (is_left(reg_addr))
					reg_rdata <= left_mix_q;
				else
					reg_rdata <= 8'h00; // unmapped reads give zero
			end
		end
	end

	// third mic left into the right mix
	// reset already shows unconnected; the attenuation matches the byte only after the first edge
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			third_mic_left_conn <= 1'b0;
			third_mic_left_atten_cdb <= 7'h00;
		end else begin
			third_mic_left_conn <= connected(right_mix_q[7:4]);
			third_mic_left_atten_cdb <= atten_cdb(right_mix_q[7:4]);
		end
	end

	// third mic right into the right mix
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			third_mic_right_conn <= 1'b0;
			third_mic_right_atten_cdb <= 7'h00;
		end else begin
			third_mic_right_conn <= connected(right_mix_q[3:0]);
			third_mic_right_atten_cdb <= atten_cdb(right_mix_q[3:0]);
		end
	end

	// first line left into the left mix
	// mode is passed on as stored; keeping both channels alike is the host's job
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_line_left_diff <= 1'b0;
			first_line_left_conn <= 1'b0;
			first_line_left_atten_cdb <= 7'h00;
		end else begin
			first_line_left_diff <= left_mix_q[`F_DIFF];
			first_line_left_conn <= connected(left_mix_q[`F_LVL_HI:`F_LVL_LO]);
			first_line_left_atten_cdb <= atten_cdb(left_mix_q[`F_LVL_HI:`F_LVL_LO]);
		end
	end

	// left adc channel power
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			left_adc_power <= 1'b0;
		else
			left_adc_power <= left_mix_q[`F_PWR];
	end

	// applied gain code and its value in 0.01 dB
	// the product is registered so no multiplier sits on an output path
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			left_gain_applied <= {GW{1'b0}};
			left_gain_cdb <= 10'h000;
		end else begin
			left_gain_applied <= gain_now;
			left_gain_cdb <= gain_now * `GAIN_STEP_CDB;
		end
	end
endmodule // adc_input_mix_control_regs

// ### sim/mix_props.sv
// checker on the input-mix register bank ports
// bound into the bank; one clock, async reset
`timescale 1ns/1ns
module mix_props (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// register access
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire reg_hit,
	// decoded controls
	input wire first_line_left_diff,
	input wire left_adc_power
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// a left write, a quiet edge, then a read back
	sequence wr_l;
		reg_wr && reg_addr == 8'h13;
	endsequence
	sequence wr_rd;
		wr_l ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h13;
	endsequence
	diff_bit_a: assert property (wr_l |-> ##2 first_line_left_diff == $past(reg_wdata[7], 2))
		else $error("diff");
	power_bit_a: assert property (wr_l |-> ##2 left_adc_power == $past(reg_wdata[2], 2))
		else $error("power");
	diff_hold_a: assert property (!$stable(first_line_left_diff) |-> $past(reg_wr, 2))
		else $error("diff moved");
	power_hold_a: assert property (!$stable(left_adc_power) |-> $past(reg_wr, 2))
		else $error("power moved");
	mapped_hit_a: assert property (reg_rd && reg_addr[7:1] == 7'h09 |=> reg_hit)
		else $error("no hit");
	unmapped_rd_a: assert property (reg_rd && reg_addr[7:1] != 7'h09 |=> !reg_hit)
		else $error("stray hit");
	hit_cause_a: assert property (reg_hit |-> $past(reg_rd))
		else $error("hit");
	left_readback_a: assert property (wr_rd |=> reg_rdata == $past(reg_wdata, 3))
		else $error("readback");
endmodule // mix_props
bind adc_input_mix_control_regs mix_props u_props (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_hit(reg_hit),
	.first_line_left_diff(first_line_left_diff),
	.left_adc_power(left_adc_power)
);

// ### sim/host_model.sv
// host model making single register byte accesses
// assumes each call waits for the previous one to end
`timescale 1ns/1ns
module host_model (
	// clock
	input wire core_clk,
	// register strobes
	output reg reg_wr,
	output reg reg_rd,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
	// strobe dropped at the taking edge, so calls never collide
	task acc(input w, input [7:0] a, input [7:0] d);
		@(posedge core_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1;
	endtask
endmodule // host_model

// ### sim/tb.sv
// bench for the input-mix register bank
// host model makes accesses; data from an lfsr
`timescale 1ns/1ns
module tb;
	reg core_clk = 0, arst_n = 0, fs_tick = 0;
	reg [6:0] left_gain_target = 7'h05;
	reg [31:0] lf = 32'h1A2F;
	reg [7:0] v;
	wire reg_wr, reg_rd, reg_hit, third_mic_left_conn, third_mic_right_conn;
	wire first_line_left_diff, first_line_left_conn, left_adc_power;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [6:0] third_mic_left_atten_cdb, third_mic_right_atten_cdb;
	wire [6:0] first_line_left_atten_cdb;
	wire [6:0] left_gain_applied;
	wire [9:0] left_gain_cdb;
	integer n_mismatch = 0, comparisons = 0, i;
	host_model hm (.*);
	adc_input_mix_control_regs uut (.*);
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], ^(s & 32'h80200003)};
	endfunction
	// host never sends reserved levels
	function [3:0] lg(input [3:0] c);
		lg = (c > 4'h8 && c < 4'hF) ? 4'h8 : c;
	endfunction
	function [6:0] at(input [3:0] c);
		at = c > 4'h8 ? 7'h78 : c * 7'h0F;
	endfunction
	task chk(input string n, input [15:0] e, input [15:0] g);
		comparisons = comparisons + 1;
		if (e !== g) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task tk(input integer n, input [6:0] t);
		@(posedge core_clk) left_gain_target <= t;
		repeat (n) begin
			@(posedge core_clk) fs_tick <= 1'h1;
			@(posedge core_clk) fs_tick <= 1'h0;
		end
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task results;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #20 core_clk = ~core_clk;
	// run needs about 150 cycles
	initial begin
		#20000 n_mismatch = n_mismatch + 1;
		results;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'h1;
		hm.acc(0, 8'h12, 8'h00);
		chk("rst r", 16'h03FE, {6'h00, reg_hit, reg_rdata, third_mic_left_conn});
		hm.acc(0, 8'h13, 8'h00);
		chk("rst l", 16'h02F0, {6'h00, reg_hit, reg_rdata, first_line_left_conn});
		hm.acc(0, 8'h11, 8'h00);
		chk("unmapped", 16'h0000, {7'h00, reg_hit, reg_rdata});
		// corner: deepest level on the left mic, right mic disconnected
		hm.acc(1, 8'h12, 8'h8F);
		hm.acc(0, 8'h12, 8'h00);
		chk("corner", {2'h2, at(4'h8), at(4'hF)}, {third_mic_left_conn, third_mic_right_conn,
			third_mic_left_atten_cdb, third_mic_right_atten_cdb});
		for (i = 0; i < 24; i = i + 1) begin
			lf = nx(lf);
			// line mode taken as it comes from the lfsr; only the levels are kept off reserved codes
			v = lf[8] ? {lf[7], lg(lf[6:3]), lf[2:0]} : {lg(lf[7:4]), lg(lf[3:0])};
			hm.acc(1, {7'h09, lf[8]}, v);
			hm.acc(0, {7'h09, lf[8]}, 8'h00);
			chk("readback", {8'h00, v}, {8'h00, reg_rdata});
			if (lf[8]) chk("left", {6'h00, v[7], v[2], v[6:3] != 4'hF, at(v[6:3])},
				{6'h00, first_line_left_diff, left_adc_power, first_line_left_conn,
				first_line_left_atten_cdb});
			else chk("right", {v[7:4] != 4'hF, v[3:0] != 4'hF, at(v[7:4]), at(v[3:0])},
				{third_mic_left_conn, third_mic_right_conn, third_mic_left_atten_cdb,
				third_mic_right_atten_cdb});
		end
		// rates 10, 00, 01, 11 in turn
		hm.acc(1, 8'h13, 8'h02);
		tk(0, 7'h05);
		chk("gain", 16'h00FA, {6'h00, left_gain_cdb});
		chk("gain code", 16'h0005, {9'h000, left_gain_applied});
		hm.acc(1, 8'h13, 8'h00);
		tk(1, 7'h08);
		chk("step", 16'h012C, {6'h00, left_gain_cdb});
		hm.acc(1, 8'h13, 8'h01);
		tk(2, 7'h08);
		chk("step2", 16'h015E, {6'h00, left_gain_cdb});
		hm.acc(1, 8'h13, 8'h03);
		tk(0, 7'h08);
		chk("off", 16'h0190, {6'h00, left_gain_cdb});
		chk("off code", 16'h0008, {9'h000, left_gain_applied});
		results;
	end
endmodule // tb
